// *** hw/scd_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scd_cfg.svh"
// Functional notes
// - each strap resolves to one of five levels, L0 to L4
// - mode L0 selects pin control, L1 or L2 register control, L3/L4 reserved
// - channels 0-1 form bank 0, 2-3 bank 1, each at its own address
// - straps sampled once after power-on reset release; addresses come from it
// - mode L1: bank 0 at 0x18/1A/1C/1E by address strap, bank 1 one above
// - mode L2: bank 0 at 0x20/22/24/26, bank 1 one above, up to 0x27
// - pin control: one index, five times high strap plus low strap, 0 to 19
// - register control: per-channel equalizer set by host writes
// - power-down low, detect L0: detect machine off, inputs always terminated
// - detect L1: poll until three consecutive valid detections
// - detect L2: poll until two consecutive valid detections
// - detect L4: poll about every 150 us until valid termination; L3 reserved
// - power-down high: detect logic held in reset, inputs high impedance
// - detection cycle runs at power up and after power-down release
// - pin control: gain from gain strap, L4 meaning 0 dB
// - register control: per-channel gain set by host writes
module scd_top (
   input wire logic clk, // 20 MHz system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped offset
   input wire scd_pkg::scd_straps_type straps, // strap level codes
   input wire logic scl_pin, // clock line view of detect strap
   input wire logic sda_in, // data line input
   output logic sda_out, // data line drive value
   output logic sda_oe, // data line output enable
   input wire logic power_down_pin, // power-down, active high
   input wire logic por_done, // internal power-on reset released
   input wire logic det_valid, // far-end probe result ready
   input wire logic det_present, // far-end termination seen
   output logic det_probe, // one-cycle request for a probe
   output logic term_found, // valid far-end termination found
   output logic inputs_hiz, // inputs high impedance
   output logic inputs_term, // inputs terminated
   output logic reg_mode, // register control selected
   output logic [6:0] bank0_addr, // bank 0 target address
   output logic [6:0] bank1_addr, // bank 1 target address
   output logic [19:0] eq_ch, // four 5-bit equalizer indices
   output logic [11:0] gain_ch // four 3-bit gain levels
);
   scd_pkg::scd_state_type st_r;
   scd_pkg::scd_state_type st_nxt;
   scd_pkg::scd_straps_type straps_s;
   logic scl_s;
   logic pd_s;
   logic por_s;
   logic dv_s;
   logic dp_s;
   logic access;

   // every pin input passes two flops before use
   scd_sync #(.W(20)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({straps, scl_pin, power_down_pin, por_done, det_valid, det_present}),
      .q({straps_s, scl_s, pd_s, por_s, dv_s, dp_s})
   );

   // comparator codes above L4 read as a floating pin
   function automatic logic [2:0] lvl(input logic [2:0] x);
      lvl = (x > `SCD_L4) ? `SCD_L4 : x;
   endfunction

   // consecutive detections needed per detect level
   function automatic logic [1:0] need(input logic [2:0] d);
      unique case (d)
         `SCD_L1: need = `SCD_NEED_L1;
         `SCD_L2: need = `SCD_NEED_L2;
         default: need = `SCD_NEED_L4;
      endcase
   endfunction

   assign access = psel & penable;

   always_comb begin
      logic [4:0] pin_idx;
      logic [6:0] base;
      logic start_off;
      pin_idx = '0;
      base = '0;
      start_off = 1'b0;
      st_nxt = st_r;
      st_nxt.probe = 1'b0;
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;

      // one-shot strap capture after power-on reset release
      if (!st_r.sampled && por_s) begin
         st_nxt.sampled = 1'b1;
         st_nxt.smp.mode_strap = lvl(straps_s.mode_strap);
         st_nxt.smp.eq_low_addr_strap = lvl(straps_s.eq_low_addr_strap);
         st_nxt.smp.eq_high_strap = lvl(straps_s.eq_high_strap);
         st_nxt.smp.detect_cfg_scl_strap = lvl(straps_s.detect_cfg_scl_strap);
         st_nxt.smp.dc_gain_sda_strap = lvl(straps_s.dc_gain_sda_strap);
         st_nxt.regm = (straps_s.mode_strap == `SCD_L1) ||
                       (straps_s.mode_strap == `SCD_L2);
         base = (straps_s.mode_strap == `SCD_L1) ? `SCD_BASE_L1 : `SCD_BASE_L2;
         // address strap L4 has no pair; it maps to the top pair
         if (lvl(straps_s.eq_low_addr_strap) > `SCD_L3) begin
            base = base + 7'h06;
         end else begin
            base = base + {3'h0, lvl(straps_s.eq_low_addr_strap), 1'b0};
         end
         st_nxt.b0 = st_nxt.regm ? base : 7'h00;
         st_nxt.b1 = st_nxt.regm ? (base | 7'h01) : 7'h00;
      end

      // pin-mode equalizer index; a high strap at L4 saturates
      if (st_r.smp.eq_high_strap > `SCD_L3) begin
         pin_idx = `SCD_EQ_MAX;
      end else begin
         pin_idx = 5'(st_r.smp.eq_high_strap) * `SCD_EQ_STEP +
                   5'(st_r.smp.eq_low_addr_strap);
      end
      if (st_r.regm) begin
         st_nxt.eq_ch = st_r.eq_reg;
         st_nxt.gain_ch = st_r.gain_reg;
      end else if (st_r.sampled) begin
         st_nxt.eq_ch = {4{pin_idx}};
         st_nxt.gain_ch = {4{st_r.smp.dc_gain_sda_strap}};
      end

      // detect machine, idle until the straps are known
      start_off = (st_r.smp.detect_cfg_scl_strap == `SCD_L0) ||
                  (st_r.smp.detect_cfg_scl_strap == `SCD_L3);
      if (!st_r.sampled || pd_s) begin
         st_nxt.dst = scd_pkg::SCD_DS_HIZ;
         st_nxt.term = 1'b0;
         st_nxt.good = '0;
         st_nxt.timer = '0;
      end else begin
         unique case (st_r.dst)
            scd_pkg::SCD_DS_HIZ: begin
               // leaving reset or power-down starts a fresh cycle
               st_nxt.timer = '0;
               st_nxt.good = '0;
               if (start_off) begin
                  st_nxt.dst = scd_pkg::SCD_DS_OFF;
               end else begin
                  st_nxt.dst = scd_pkg::SCD_DS_PROBE;
                  st_nxt.probe = 1'b1;
               end
            end
            scd_pkg::SCD_DS_OFF: begin
               st_nxt.dst = scd_pkg::SCD_DS_OFF;
            end
            scd_pkg::SCD_DS_WAIT: begin
               st_nxt.timer = st_r.timer + 12'h001;
               if (st_r.timer == `SCD_POLL_CYC - 12'h001) begin
                  st_nxt.timer = '0;
                  st_nxt.dst = scd_pkg::SCD_DS_PROBE;
                  st_nxt.probe = 1'b1;
               end
            end
            scd_pkg::SCD_DS_PROBE: begin
               st_nxt.timer = st_r.timer + 12'h001;
               if (dv_s && dp_s) begin
                  st_nxt.timer = '0;
                  st_nxt.good = st_r.good + 2'h1;
                  if (st_r.good + 2'h1 == need(st_r.smp.detect_cfg_scl_strap)) begin
                     st_nxt.dst = scd_pkg::SCD_DS_DONE;
                     st_nxt.term = 1'b1;
                  end else begin
                     st_nxt.dst = scd_pkg::SCD_DS_WAIT;
                  end
               end else if (dv_s || st_r.timer == `SCD_WIN_CYC - 12'h001) begin
                  // a miss or a silent probe breaks the run
                  st_nxt.timer = '0;
                  st_nxt.good = '0;
                  st_nxt.dst = scd_pkg::SCD_DS_WAIT;
               end
            end
            scd_pkg::SCD_DS_DONE: begin
               st_nxt.dst = scd_pkg::SCD_DS_DONE;
            end
            default: begin
               st_nxt.dst = scd_pkg::SCD_DS_HIZ;
            end
         endcase
      end

      // clock line activity once the strap pins turn into the two-wire port
      st_nxt.scl_prev = scl_s;
      if (st_r.regm && scl_s && !st_r.scl_prev) begin
         st_nxt.scl_cnt = st_r.scl_cnt + 8'h01;
      end

      // apb: one wait state, data and error staged with pready
      if (access && !st_r.ready) begin
         st_nxt.ready = 1'b1;
         st_nxt.rdata = '0;
         unique case (paddr)
            `SCD_OFS_STAT: st_nxt.rdata = {11'h000, st_r.term, st_r.dst,
                                           st_r.smp, st_r.regm, st_r.sampled};
            `SCD_OFS_ADDR: st_nxt.rdata = {17'h00000, st_r.b1, 1'b0, st_r.b0};
            `SCD_OFS_EQ: st_nxt.rdata = {12'h000, st_r.eq_reg};
            `SCD_OFS_GAIN: st_nxt.rdata = {20'h00000, st_r.gain_reg};
            `SCD_OFS_LINK: st_nxt.rdata = {24'h000000, st_r.scl_cnt};
            default: st_nxt.err = 1'b1;
         endcase
      end
      // write lands on the edge that sees pready; pin mode ignores it
      if (access && st_r.ready && pwrite && st_r.regm) begin
         if (paddr == `SCD_OFS_EQ) begin
            st_nxt.eq_reg = pwdata[19:0];
         end
         if (paddr == `SCD_OFS_GAIN) begin
            st_nxt.gain_reg = pwdata[11:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.dst <= scd_pkg::SCD_DS_HIZ;
         st_r.eq_reg <= `SCD_EQ_RST;
         st_r.gain_reg <= `SCD_GAIN_RST;
         st_r.eq_ch <= `SCD_EQ_RST;
         st_r.gain_ch <= `SCD_GAIN_RST;
         st_r.scl_prev <= 1'b1; // clock line idles high: no false edge after reset
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign det_probe = st_r.probe;
   assign term_found = st_r.term;
   assign inputs_hiz = (st_r.dst == scd_pkg::SCD_DS_HIZ);
   assign inputs_term = (st_r.dst != scd_pkg::SCD_DS_HIZ);
   assign reg_mode = st_r.regm;
   assign bank0_addr = st_r.b0;
   assign bank1_addr = st_r.b1;
   assign eq_ch = st_r.eq_ch;
   assign gain_ch = st_r.gain_ch;
   // no two-wire slave behind the pins yet: data line only released
   assign sda_out = 1'b0;
   assign sda_oe = 1'b0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_level_range: assert property (st_r.sampled |-> st_r.smp.mode_strap <= `SCD_L4 &&
      st_r.smp.detect_cfg_scl_strap <= `SCD_L4)
      else $error("strap level out of range");
   chk_pin_mode: assert property (st_r.sampled && st_r.smp.mode_strap != `SCD_L1 &&
      st_r.smp.mode_strap != `SCD_L2 |-> !reg_mode)
      else $error("register mode on wrong mode level");
   chk_bank_pair: assert property (reg_mode |-> bank1_addr == (bank0_addr | 7'h01) &&
      !bank0_addr[0])
      else $error("bank pair mismatch");
   chk_sample_once: assert property ($past(st_r.sampled) |-> $stable(st_r.smp) &&
      $stable(bank0_addr))
      else $error("strap sample changed");
   chk_addr_l1: assert property (reg_mode && st_r.smp.mode_strap == `SCD_L1 &&
      st_r.smp.eq_low_addr_strap <= `SCD_L3 |->
      bank0_addr == `SCD_BASE_L1 + {3'h0, st_r.smp.eq_low_addr_strap, 1'b0})
      else $error("mode L1 address wrong");
   chk_addr_l2: assert property (reg_mode && st_r.smp.mode_strap == `SCD_L2 |->
      bank0_addr >= `SCD_BASE_L2 && bank1_addr <= 7'h27)
      else $error("mode L2 address wrong");
   chk_pin_eq: assert property (st_r.sampled && !reg_mode && st_r.smp.eq_high_strap == `SCD_L1
      |=> eq_ch[4:0] == 5'(`SCD_EQ_STEP + 5'($past(st_r.smp.eq_low_addr_strap))) &&
      eq_ch[19:15] == eq_ch[4:0])
      else $error("pin equalizer index wrong");
   chk_reg_eq: assert property (access && pready && pwrite && reg_mode &&
      paddr == `SCD_OFS_EQ |=> st_r.eq_reg == $past(pwdata[19:0]))
      else $error("equalizer write lost");
   chk_det_off: assert property (st_r.dst == scd_pkg::SCD_DS_OFF |->
      inputs_term && !det_probe && !inputs_hiz)
      else $error("detect off misbehaves");
   chk_det_count: assert property ($rose(term_found) |->
      $past(st_r.good) == need(st_r.smp.detect_cfg_scl_strap) - 2'h1)
      else $error("wrong detection run length");
   chk_poll_gap: assert property (st_r.dst == scd_pkg::SCD_DS_WAIT |->
      st_r.timer < `SCD_POLL_CYC)
      else $error("poll interval overrun");
   chk_pd_hold: assert property (pd_s |=> inputs_hiz && !term_found ##1
      (inputs_hiz || !pd_s))
      else $error("power-down not held");
   chk_pd_release: assert property ($fell(pd_s) && st_r.sampled &&
      st_r.smp.detect_cfg_scl_strap == `SCD_L4 |=> det_probe)
      else $error("no probe after release");
   chk_pin_gain: assert property (st_r.sampled && !reg_mode |=>
      gain_ch[2:0] == $past(st_r.smp.dc_gain_sda_strap))
      else $error("pin gain wrong");
   chk_link_idle: assert property (!reg_mode |-> $stable(st_r.scl_cnt) && !sda_oe)
      else $error("link active in pin mode");

   cov_reg_mode: cover property ($rose(reg_mode));
   cov_found3: cover property ($rose(term_found) && st_r.smp.detect_cfg_scl_strap == `SCD_L1);
   cov_pd_cycle: cover property ($fell(pd_s) ##[1:10] det_probe);
   cov_apb_err: cover property (pslverr);
endmodule
`default_nettype wire

// *** hw/scd_cfg.svh ***
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH
// five strap levels as delivered by the level comparator
`define SCD_L0 3'h0
`define SCD_L1 3'h1
`define SCD_L2 3'h2
`define SCD_L3 3'h3
`define SCD_L4 3'h4
// bus target address bases and equalizer index figures
`define SCD_BASE_L1 7'h18
`define SCD_BASE_L2 7'h20
`define SCD_EQ_STEP 5'h05
`define SCD_EQ_MAX 5'h13
// detect timing
`define SCD_CLK_NS 50
`define SCD_POLL_US 150
`define SCD_POLL_CYC 12'((`SCD_POLL_US * 1000) / `SCD_CLK_NS)
`define SCD_WIN_CYC 12'h040
`define SCD_NEED_L1 2'h3
`define SCD_NEED_L2 2'h2
`define SCD_NEED_L4 2'h1
// register offsets
`define SCD_OFS_STAT 8'h00
`define SCD_OFS_ADDR 8'h04
`define SCD_OFS_EQ 8'h08
`define SCD_OFS_GAIN 8'h0C
`define SCD_OFS_LINK 8'h10
// reset values: equalizer index 0, gain level L4 (0 dB) on all channels
`define SCD_EQ_RST 20'h00000
`define SCD_GAIN_RST 12'h924
`endif

// *** hw/scd_pkg.sv ***
package scd_pkg;
   typedef struct packed {
      logic [2:0] mode_strap;
      logic [2:0] eq_low_addr_strap;
      logic [2:0] eq_high_strap;
      logic [2:0] detect_cfg_scl_strap;
      logic [2:0] dc_gain_sda_strap;
   } scd_straps_type;

   typedef enum logic [2:0] {
      SCD_DS_OFF = 3'b000,
      SCD_DS_HIZ = 3'b001,
      SCD_DS_WAIT = 3'b010,
      SCD_DS_PROBE = 3'b011,
      SCD_DS_DONE = 3'b100
   } scd_det_type;

   typedef struct packed {
      scd_straps_type smp;
      logic sampled;
      logic regm;
      logic [6:0] b0;
      logic [6:0] b1;
      scd_det_type dst;
      logic [11:0] timer;
      logic [1:0] good;
      logic term;
      logic probe;
      logic [19:0] eq_reg;
      logic [11:0] gain_reg;
      logic [19:0] eq_ch;
      logic [11:0] gain_ch;
      logic scl_prev;
      logic [7:0] scl_cnt;
      logic ready;
      logic err;
      logic [31:0] rdata;
   } scd_state_type;
endpackage

// *** hw/scd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module scd_sync #(
   parameter int W = 1
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q // synchronised copy
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } scd_sync_st_type;
   scd_sync_st_type st_r;
   scd_sync_st_type st_nxt;

   // first stage feeds only the second
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule
`default_nettype wire

// *** tb/scd_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// far-end receiver: answers each probe request with a termination result
module scd_far_end (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic det_probe, // probe request pulse
   input wire logic [1:0] misses, // first probes answered as absent
   input wire logic slow, // late answer, still inside the window
   output logic det_valid, // result strobe, held four cycles
   output logic det_present, // termination seen
   output int probes // probes seen since reset
);
   int wait_n;
   int hold_n;
   // result held long enough for the two-flop sync, then the line wanders
   always @(posedge clk) begin
      if (rst) begin
         probes <= 0;
         wait_n <= 0;
         hold_n <= 0;
         det_valid <= 1'b0;
         det_present <= 1'b0;
      end else if (det_probe) begin
         probes <= probes + 1;
         wait_n <= slow ? 30 : 2;
      end else if (wait_n > 1) begin
         wait_n <= wait_n - 1;
      end else if (wait_n == 1) begin
         wait_n <= 0;
         hold_n <= 4;
         det_valid <= 1'b1;
         det_present <= (probes > misses);
      end else if (hold_n > 1) begin
         hold_n <= hold_n - 1;
      end else if (hold_n == 1) begin
         hold_n <= 0;
         det_valid <= 1'b0;
         det_present <= ~det_present; // released: not the last value
      end
   end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scd_cfg.svh"
module testbench;
   logic clk, rst, psel, penable, pwrite, scl_pin, sda_in, power_down_pin, por_done;
   logic pready, pslverr, det_valid, det_present, det_probe, term_found, inputs_hiz;
   logic inputs_term, reg_mode, slow, term_prev;
   logic [1:0] misses;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0] bank0_addr, bank1_addr, b0;
   logic [19:0] eq_ch, ev;
   logic [11:0] gain_ch, gv;
   logic [4:0] idx;
   logic [32:0] exp_e;
   scd_pkg::scd_straps_type straps;
   int errors, samples_checked, seed, probes, det_base, h, l, g, m, a;
   logic [32:0] exp_q[$];
   int det_q[$];

   // 20 MHz system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   scd_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .straps(straps), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(), .sda_oe(),
      .power_down_pin(power_down_pin), .por_done(por_done), .det_valid(det_valid),
      .det_present(det_present), .det_probe(det_probe), .term_found(term_found),
      .inputs_hiz(inputs_hiz), .inputs_term(inputs_term), .reg_mode(reg_mode),
      .bank0_addr(bank0_addr), .bank1_addr(bank1_addr), .eq_ch(eq_ch), .gain_ch(gain_ch));

   scd_far_end u_far (.clk(clk), .rst(rst), .det_probe(det_probe), .misses(misses),
      .slow(slow), .det_valid(det_valid), .det_present(det_present), .probes(probes));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) chk(32'h1, 32'h0, "no pready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, ad, 32'h0);
   endtask

   // reset, then straps settle before por and wander after the sample
   task automatic cfg(input int mm, input int aa, input int hh, input int dd, input int gg);
      logic [14:0] s;
      s = {mm[2:0], aa[2:0], hh[2:0], dd[2:0], gg[2:0]};
      @(posedge clk);
      rst <= 1'b1;
      por_done <= 1'b0;
      power_down_pin <= 1'b0;
      straps <= s ^ 15'h1249;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      straps <= s;
      repeat (4) @(posedge clk);
      por_done <= 1'b1;
      repeat (6) @(posedge clk);
      straps <= 15'($random(seed));
      repeat (3) @(posedge clk);
   endtask

   task automatic detect(input string nm, input int need, input int base);
      int n;
      det_base = base;
      det_q.push_back(need);
      n = 0;
      while (term_found !== 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, term_found}, 32'h1, "term_found");
      @(posedge clk);
      chk({30'h0, inputs_hiz, inputs_term}, 32'h1, "terminated");
      $display("test %s done", nm);
   endtask

   // results taken off the queues as they appear
   always @(posedge clk) begin
      term_prev <= term_found;
      if (term_found === 1'b1 && term_prev === 1'b0) begin
         if (det_q.size() == 0) chk(32'h1, 32'h0, "stray term_found");
         else chk(probes - det_base, det_q.pop_front(), "probe count");
      end
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0, "stray read");
         else begin
            exp_e = exp_q.pop_front();
            chk(prdata, exp_e[31:0], "read data");
            chk({31'h0, pslverr}, {31'h0, exp_e[32]}, "read error");
         end
      end
   end

   // sized to the slowest detection runs with a wide margin
   initial begin
      #5000000;
      chk(32'h1, 32'h0, "watchdog");
      summarize();
   end

   initial begin
      seed = 9118;
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      scl_pin = 1'b1;
      sda_in = 1'b1;
      power_down_pin = 1'b0;
      por_done = 1'b0;
      straps = 15'h0000;
      misses = 2'h0;
      slow = 1'b0;
      term_prev = 1'b0;
      det_base = 0;
      // address pairs; address level L4 falls back to the L3 pair
      for (m = 1; m < 3; m++) begin
         for (a = 0; a < 5; a++) begin
            cfg(m, a, 0, 0, 4);
            b0 = (m == 1 ? `SCD_BASE_L1 : `SCD_BASE_L2) + 7'(2 * (a > 3 ? 3 : a));
            chk({31'h0, reg_mode}, 32'h1, "reg_mode");
            chk({25'h0, bank0_addr}, {25'h0, b0}, "bank0");
            chk({25'h0, bank1_addr}, {25'h0, b0 + 7'h01}, "bank1");
            chk({30'h0, inputs_hiz, inputs_term}, 32'h1, "detect off");
            rd(8'h04, {18'h0, b0 + 7'h01, 1'b0, b0});
         end
      end
      $display("test address map done");
      // pin control, gain codes above L4 read as L4
      for (h = 0; h < 5; h++) begin
         l = (h == 4) ? 4 : {$random(seed)} % 5;
         g = {$random(seed)} % 8;
         cfg(0, l, h, 0, g);
         idx = (h == 4) ? `SCD_EQ_MAX : 5'(5 * h + l);
         gv = {4{3'(g > 4 ? 4 : g)}};
         chk({12'h0, eq_ch}, {12'h0, {4{idx}}}, "pin eq");
         chk({20'h0, gain_ch}, {20'h0, gv}, "pin gain");
         chk({31'h0, reg_mode}, 32'h0, "pin mode");
         apb(1'b1, 8'h08, 32'h0000_0421);
         rd(8'h08, {13'h0, `SCD_EQ_RST});
      end
      $display("test pin control done");
      // register control: per-channel settings from the host
      cfg(1, 0, 0, 0, 4);
      rd(8'h0C, {21'h0, `SCD_GAIN_RST});
      rd(8'h00, {13'h0, 3'h0, 15'h1004, 2'h3});
      for (a = 0; a < 4; a++) begin
         ev[a*5 +: 5] = 5'({$random(seed)} % 20);
         gv[a*3 +: 3] = 3'({$random(seed)} % 5);
      end
      apb(1'b1, 8'h08, {12'h0, ev});
      apb(1'b1, 8'h0C, {20'h0, gv});
      rd(8'h08, {13'h0, ev});
      rd(8'h0C, {21'h0, gv});
      chk({12'h0, eq_ch}, {12'h0, ev}, "reg eq");
      chk({20'h0, gain_ch}, {20'h0, gv}, "reg gain");
      rd(8'h14, {1'b1, 32'h0});
      // ten clock-line pulses at the 400 ns link rate
      repeat (10) begin
         repeat (4) @(posedge clk);
         scl_pin <= 1'b0;
         repeat (4) @(posedge clk);
         scl_pin <= 1'b1;
      end
      repeat (4) @(posedge clk);
      rd(8'h10, {25'h0, 8'h0A});
      $display("test register control done");
      // detection policies
      slow <= 1'b1;
      cfg(0, 0, 0, 1, 4);
      detect("three hits", 3, 0);
      slow <= 1'b0;
      misses <= 2'h1;
      cfg(0, 0, 0, 2, 4);
      detect("miss then two hits", 3, 0);
      cfg(0, 0, 0, 4, 4);
      detect("poll until hit", 2, 0);
      power_down_pin <= 1'b1;
      repeat (6) @(posedge clk);
      chk({29'h0, term_found, inputs_hiz, inputs_term}, 32'h2, "power down");
      a = probes;
      power_down_pin <= 1'b0;
      detect("restart after power down", 1, a);
      summarize();
   end
endmodule
`default_nettype wire
